// ==== hdl/sbq_pkg.sv ====
// package: register map, field positions and codes of the batching queue status block
package sbq_pkg;
   // register offsets (byte addresses, chosen)
   localparam logic [7:0] OFF_RATE_MODE   = 8'h00;
   localparam logic [7:0] OFF_CNT_UPPER   = 8'h04;
   localparam logic [7:0] OFF_CNT_LOWER   = 8'h08;
   localparam logic [7:0] OFF_LEVEL_LOWER = 8'h0c;
   localparam logic [7:0] OFF_FLAGS_UPPER = 8'h10;
   localparam logic [7:0] OFF_WORD_TAG    = 8'h14;
   localparam logic [7:0] OFF_BATCH_RATE  = 8'h18;
   localparam logic [7:0] OFF_WATERMARK   = 8'h1c;
   localparam logic [7:0] OFF_PIN_ROUTE   = 8'h20;
   localparam logic [7:0] OFF_MISC        = 8'h24;
   // field positions
   localparam int DEC_LSB    = 6;
   localparam int TEMP_LSB   = 4;
   localparam int CLR_BIT    = 6;
   localparam int SRC_BIT    = 5;
   localparam int FL_WTM     = 7;
   localparam int FL_OVR     = 6;
   localparam int FL_FULL    = 5;
   localparam int FL_CNT     = 4;
   localparam int FL_STICKY  = 3;
   localparam int TAG_ID_LSB = 3;
   localparam int TAG_TS_LSB = 1;
   // sizes
   localparam int DEPTH      = 512;
   localparam int LVL_W      = 10;
   localparam int WTM_W      = 9;
   localparam int THR_W      = 11;
   localparam int RATE_W     = 4;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // source identifiers of main sensor words
   localparam logic [4:0] ID_GYRO_NC  = 5'h01;
   localparam logic [4:0] ID_ACC_NC   = 5'h02;
   localparam logic [4:0] ID_ACC_T2   = 5'h06;
   localparam logic [4:0] ID_ACC_3C   = 5'h09;
   localparam logic [4:0] ID_GYRO_T2  = 5'h0a;
   localparam logic [4:0] ID_GYRO_3C  = 5'h0d;
   // rate codes
   localparam logic [3:0] RATE_OFF    = 4'h0;
   localparam logic [3:0] RATE_6667   = 4'ha;
   localparam logic [3:0] RATE_LOWEST = 4'hb;
   localparam logic [1:0] DEC_OFF     = 2'h0;
   localparam logic [1:0] DEC_DIV8    = 2'h2;
   localparam logic [1:0] DEC_DIV32   = 2'h3;
   localparam logic [1:0] TEMP_OFF    = 2'h0;
endpackage

// ==== hdl/sbq_status.sv ====
// batching queue configuration, occupancy, flags, counter and tag logic with apb access
//
// Behaviour
// - gyro rate code 0 off, 1..10 ascending, 11 slowest
// - stamp decimation off, divide by 1, 8, 32
// - temperature rate off or three rates
// - rate-mode register field layout, bit 3 zero
// - clear bit zeroes batch counter, self-clearing
// - source bit selects accel or gyro counting
// - eleven bit threshold split, bits 4:3 zero
// - counter-reached sets at threshold, clears on read
// - ten bit unread word count split
// - watermark high when count at or above level
// - overrun on overwrite, clears on word read
// - full-pending when next write fills or overruns
// - sticky overrun clears only on upper read
// - four conditions routable to two pins
// - status tracks every queue write and read
// - lower status read freezes pair for upper
// - tag holds id, slot count, parity
// - parity makes tag ones count even
// - slot count wraps on fastest main event
// - storage is 512 seven-byte words
// - watermark level nine bits wide
`timescale 1ns/1ps
module sbq_status #(
   parameter int DEPTH = sbq_pkg::DEPTH
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wr_valid,
   input  wire logic [4:0]  wr_source_id,
   input  wire logic        rd_word,
   input  wire logic        accel_batch_event,
   input  wire logic        gyro_batch_event,
   output logic [3:0]       gyro_batch_rate,
   output logic [3:0]       accel_batch_rate,
   output logic [1:0]       stamp_decimation,
   output logic [1:0]       temp_batch_rate,
   output logic [2:0]       queue_mode,
   output logic             queue_occupied,
   output logic             int1_out,
   output logic             int2_out
);
   // queue occupancy never exceeds the storage
   localparam logic [9:0] FULL_LVL = 10'(DEPTH);

   typedef struct packed {
      logic [7:0]  rate_mode;
      logic [7:0]  cnt_upper;
      logic [7:0]  cnt_lower;
      logic [7:0]  batch_rate;
      logic [8:0]  watermark_level;
      logic [7:0]  pin_route;
      logic        block_update_hold;
      logic [9:0]  unread_word_count;
      logic        overrun_flag;
      logic        overrun_sticky;
      logic        batch_count_reached;
      logic [10:0] batch_count;
      logic [1:0]  time_slot_count;
      logic [7:0]  tag;
      logic        frozen;
      logic [7:0]  frozen_upper;
      logic [31:0] rdata;
      logic        ack;
   } sbq_state_t;

   sbq_state_t s_q;
   sbq_state_t s_d;

   // even parity over the top seven bits gives an even byte
   function automatic logic [7:0] sbq_tag(input logic [4:0] id, input logic [1:0] slot);
      logic [6:0] body;
      body = {id, slot};
      return {body, ^body};
   endfunction

   function automatic logic sbq_is_accel(input logic [4:0] id);
      return (id == sbq_pkg::ID_ACC_NC) || (id >= sbq_pkg::ID_ACC_T2 && id <= sbq_pkg::ID_ACC_3C);
   endfunction

   function automatic logic sbq_is_gyro(input logic [4:0] id);
      return (id == sbq_pkg::ID_GYRO_NC) || (id >= sbq_pkg::ID_GYRO_T2 && id <= sbq_pkg::ID_GYRO_3C);
   endfunction

   // rates rank by code except the lowest code, which is slowest of all
   function automatic logic [3:0] sbq_rank(input logic [3:0] code);
      logic [3:0] r;
      r = 4'h0;
      if (code == sbq_pkg::RATE_LOWEST)
         r = 4'h1;
      else if (code != sbq_pkg::RATE_OFF && code <= sbq_pkg::RATE_6667)
         r = code + 4'h1;
      return r;
   endfunction

   logic       acc_fast;
   logic       slot_event;
   logic       wr_full;
   logic       wr_over;
   logic       full_pending_flag;
   logic       watermark_reached;
   logic [7:0] upper_live;
   logic       acc;
   logic       wr_en;
   logic       rd_en;

   assign acc   = psel & penable;
   assign wr_en = acc & pwrite;
   assign rd_en = acc & ~pwrite;

   always_comb
   begin
      logic [9:0]  lvl;
      logic        cnt_inc;
      lvl = s_q.unread_word_count;
      cnt_inc = 1'b0;
      // faster main sensor owns the slot
      acc_fast = sbq_rank(s_q.batch_rate[3:0]) >= sbq_rank(s_q.batch_rate[7:4]);
      slot_event = acc_fast ? accel_batch_event : gyro_batch_event;
      wr_full = wr_valid && (lvl == FULL_LVL);
      wr_over = wr_full;
      watermark_reached = lvl >= {1'b0, s_q.watermark_level};
      full_pending_flag = (lvl >= FULL_LVL - 10'h1);
      upper_live = {watermark_reached, s_q.overrun_flag, full_pending_flag, s_q.batch_count_reached,
                    s_q.overrun_sticky, 1'b0, lvl[9:8]};

      s_d = s_q;
      s_d.rdata = 32'h0000_0000;
      // one wait state: read data is captured first and answered from a flop
      s_d.ack = acc && !s_q.ack;

      if (wr_valid && !wr_full && !(rd_word && lvl != 10'h000))
         s_d.unread_word_count = lvl + 10'h001;
      else if (rd_word && lvl != 10'h000 && !wr_valid)
         s_d.unread_word_count = lvl - 10'h001;

      if (wr_over)
         s_d.overrun_flag = 1'b1;
      else if (rd_word && lvl != 10'h000)
         s_d.overrun_flag = 1'b0;

      if (wr_valid)
         s_d.tag = sbq_tag(wr_source_id, s_q.time_slot_count);
      // wraps naturally from 3 to 0
      if (slot_event)
         s_d.time_slot_count = s_q.time_slot_count + 2'h1;

      // only the chosen main sensor counts
      if (wr_valid)
      begin
         if (s_q.cnt_upper[sbq_pkg::SRC_BIT])
            cnt_inc = sbq_is_gyro(wr_source_id);
         else
            cnt_inc = sbq_is_accel(wr_source_id);
      end
      if (cnt_inc)
         s_d.batch_count = s_q.batch_count + 11'h001;

      // apb reads, captured at the first access edge
      if (rd_en && !s_q.ack)
      begin
         case (paddr)
            sbq_pkg::OFF_RATE_MODE:   s_d.rdata = {24'h0, s_q.rate_mode};
            sbq_pkg::OFF_CNT_UPPER:   s_d.rdata = {24'h0, s_q.cnt_upper};
            sbq_pkg::OFF_CNT_LOWER:   s_d.rdata = {24'h0, s_q.cnt_lower};
            sbq_pkg::OFF_LEVEL_LOWER:
            begin
               // freeze the upper half with the lower
               s_d.rdata = {24'h0, lvl[7:0]};
               if (s_q.block_update_hold)
               begin
                  s_d.frozen = 1'b1;
                  s_d.frozen_upper = upper_live;
               end
            end
            sbq_pkg::OFF_FLAGS_UPPER:
            begin
               s_d.rdata = {24'h0, s_q.frozen ? s_q.frozen_upper : upper_live};
               s_d.frozen = 1'b0;
               s_d.batch_count_reached = 1'b0;
               s_d.overrun_sticky = 1'b0;
            end
            sbq_pkg::OFF_WORD_TAG:    s_d.rdata = {24'h0, s_q.tag};
            sbq_pkg::OFF_BATCH_RATE:  s_d.rdata = {24'h0, s_q.batch_rate};
            sbq_pkg::OFF_WATERMARK:   s_d.rdata = {23'h0, s_q.watermark_level};
            sbq_pkg::OFF_PIN_ROUTE:   s_d.rdata = {24'h0, s_q.pin_route};
            sbq_pkg::OFF_MISC:        s_d.rdata = {31'h0, s_q.block_update_hold};
            default:                  s_d.rdata = 32'h0000_0000;
         endcase
      end

      // sets are applied after the read clear so an event in that cycle wins
      // sticky overrun set
      if (wr_over)
         s_d.overrun_sticky = 1'b1;
      if (cnt_inc && (s_q.batch_count + 11'h001) == {s_q.cnt_upper[2:0], s_q.cnt_lower})
         s_d.batch_count_reached = 1'b1;

      // writes land only at the edge that completes the transfer
      if (wr_en && s_q.ack)
      begin
         case (paddr)
            sbq_pkg::OFF_RATE_MODE:  s_d.rate_mode = pwdata[7:0] & 8'hf7;
            sbq_pkg::OFF_CNT_UPPER:
            begin
               // bits 4:3 and 7 read zero
               s_d.cnt_upper = {1'b0, 1'b0, pwdata[sbq_pkg::SRC_BIT], 2'b00, pwdata[2:0]};
               // clear bit resets counter, never stored
               if (pwdata[sbq_pkg::CLR_BIT])
                  s_d.batch_count = 11'h000;
            end
            sbq_pkg::OFF_CNT_LOWER:  s_d.cnt_lower = pwdata[7:0];
            sbq_pkg::OFF_BATCH_RATE: s_d.batch_rate = pwdata[7:0];
            sbq_pkg::OFF_WATERMARK:  s_d.watermark_level = pwdata[8:0];
            sbq_pkg::OFF_PIN_ROUTE:  s_d.pin_route = pwdata[7:0];
            sbq_pkg::OFF_MISC:       s_d.block_update_hold = pwdata[0];
            default:                 s_d.rate_mode = s_q.rate_mode;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // one wait state; unmapped addresses read zero without error
   assign pready  = s_q.ack;
   assign pslverr = 1'b0;
   assign prdata  = s_q.rdata;

   // rate codes passed to the batching engine
   assign gyro_batch_rate  = s_q.batch_rate[7:4];
   assign accel_batch_rate = s_q.batch_rate[3:0];
   // decimation code, engine divides by 1, 8 or 32
   assign stamp_decimation = s_q.rate_mode[sbq_pkg::DEC_LSB +: 2];
   assign temp_batch_rate  = s_q.rate_mode[sbq_pkg::TEMP_LSB +: 2];
   assign queue_mode       = s_q.rate_mode[2:0];
   assign queue_occupied   = s_q.unread_word_count != 10'h000;

   // route bits: [3:0] pin1 wtm/ovr/full/cnt, [7:4] pin2
   assign int1_out = |(s_q.pin_route[3:0] & {s_q.batch_count_reached, full_pending_flag,
                                              s_q.overrun_flag, watermark_reached});
   assign int2_out = |(s_q.pin_route[7:4] & {s_q.batch_count_reached, full_pending_flag,
                                              s_q.overrun_flag, watermark_reached});
endmodule // sbq_status

// ==== test/sbq_status_sva.sv ====
// checker: port relations of the batching queue status block
`timescale 1ns/1ps
module sbq_status_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        wr_valid,
   input wire logic [1:0]  stamp_decimation,
   input wire logic [1:0]  temp_batch_rate,
   input wire logic [2:0]  queue_mode,
   input wire logic        queue_occupied,
   input wire logic        int1_out,
   input wire logic        int2_out
);
   wire logic       wr = psel && penable && pwrite && pready;
   wire logic       rd = psel && penable && !pwrite && !pready;
   wire logic [7:0] wbyte = pwdata[7:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   mode_write_a: assert property (
      wr && paddr == sbq_pkg::OFF_RATE_MODE |=> {stamp_decimation, temp_batch_rate, 1'b0, queue_mode}
         == ($past(wbyte) & 8'hf7)) else $error("mode fields differ from write");
   mode_read_a: assert property (
      rd && paddr == sbq_pkg::OFF_RATE_MODE |=> prdata == {24'h0, stamp_decimation, temp_batch_rate, 1'b0, queue_mode})
      else $error("mode readback differs");
   flags_resv_a: assert property (
      rd && paddr == sbq_pkg::OFF_FLAGS_UPPER |=> prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
      else $error("flags reserved bits set");
   thr_resv_a: assert property (
      rd && paddr == sbq_pkg::OFF_CNT_UPPER |=> prdata[4:3] == 2'b00) else $error("threshold reserved bits set");
   tag_parity_a: assert property (
      rd && paddr == sbq_pkg::OFF_WORD_TAG |=> ^prdata[7:0] == 1'b0) else $error("tag parity odd");
   occ_cause_a: assert property (
      $rose(queue_occupied) |-> $past(wr_valid)) else $error("occupancy rose without write");
   int_off_a: assert property (
      wr && paddr == sbq_pkg::OFF_PIN_ROUTE && wbyte == 8'h00 |=> !int1_out && !int2_out)
      else $error("pin active with routing off");
   rd_idle_a: assert property (
      !rd |=> prdata == 32'h0) else $error("read data without read");
endmodule // sbq_status_chk
bind sbq_status sbq_status_chk sbq_status_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .wr_valid(wr_valid),
   .int1_out(int1_out),
   .stamp_decimation(stamp_decimation), .temp_batch_rate(temp_batch_rate), .queue_mode(queue_mode),
   .queue_occupied(queue_occupied), .int2_out(int2_out));

// ==== test/sbq_host.sv ====
// host model: apb master making register transfers
`timescale 1ns/1ps
module sbq_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // one transfer at a time, in call order
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      // released lines show inverted values so stale data is never mistaken
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
   endtask
endmodule // sbq_host

// ==== test/sbq_status_tb.sv ====
// testbench: register and status scenarios of the batching queue block
`timescale 1ns/1ps
module sbq_status_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, occ, int1, int2;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        wr_valid = 1'b0, rd_word = 1'b0, acc_ev = 1'b0, gyr_ev = 1'b0;
   logic [4:0]  src_id = 5'h00;
   logic [3:0]  gyro_rate, acc_rate;
   logic [1:0]  dec, temp;
   logic [2:0]  mode;
   int          error_cnt = 0, tests_run = 0, cyc = 0, n = 0;
   always #25 pclk = ~pclk;
   sbq_status sbq_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_valid(wr_valid),
      .wr_source_id(src_id), .rd_word(rd_word), .accel_batch_event(acc_ev), .gyro_batch_event(gyr_ev),
      .gyro_batch_rate(gyro_rate), .accel_batch_rate(acc_rate), .stamp_decimation(dec), .temp_batch_rate(temp),
      .queue_mode(mode), .queue_occupied(occ), .int1_out(int1), .int2_out(int2));
   sbq_host sbq_host_i (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sbq_host_i.xfer(1'b1, a, {24'h0, d}, q);
      @(negedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      sbq_host_i.xfer(1'b0, a, 32'h0, q);
      chk($sformatf("reg_%h", a), {24'h0, e}, q & {24'hffffff, m});
   endtask
   task automatic fl(input logic [7:0] e);
      rd(sbq_pkg::OFF_FLAGS_UPPER, 8'hef, e);
   endtask
   task automatic pulse(input logic w, input logic r, input logic a, input logic g, input logic [4:0] id);
      @(posedge pclk);
      {wr_valid, rd_word, acc_ev, gyr_ev, src_id} <= {w, r, a, g, id};
      @(posedge pclk);
      {wr_valid, rd_word, acc_ev, gyr_ev} <= 4'h0;
      n = n + int'(w && n < 512) - int'(r);
   endtask
   task automatic put(input logic [4:0] id);
      pulse(1'b1, 1'b0, 1'b0, 1'b0, id);
   endtask
   task automatic pins(input logic e1, input logic e2);
      chk("int_pins", {30'h0, e1, e2}, {30'h0, int1, int2});
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 'h30; a += 4)
         rd(8'(a), 8'hff, (8'(a) == sbq_pkg::OFF_FLAGS_UPPER) ? 8'h80 : 8'h00);
      for (int c = 0; c < 12; c++)
      begin
         wr(sbq_pkg::OFF_BATCH_RATE, {4'(c), 4'(c)});
         chk("gyro_rate", 32'(c), {28'h0, gyro_rate});
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(sbq_pkg::OFF_RATE_MODE, {2'(i), 2'(3 - i), 1'b1, 3'(7 - i)});
         chk("stamp_dec", 32'(i), {30'h0, dec});
         chk("temp_rate", 32'(3 - i), {30'h0, temp});
      end
      wr(sbq_pkg::OFF_WATERMARK, 8'h05);
      wr(sbq_pkg::OFF_CNT_UPPER, 8'h58);
      rd(sbq_pkg::OFF_CNT_UPPER, 8'h3f, 8'h00);
      wr(sbq_pkg::OFF_CNT_LOWER, 8'h03);
      put(sbq_pkg::ID_ACC_NC);
      put(sbq_pkg::ID_GYRO_NC);
      put(sbq_pkg::ID_ACC_T2);
      fl(8'h00);
      put(sbq_pkg::ID_ACC_3C);
      rd(sbq_pkg::OFF_LEVEL_LOWER, 8'hff, 8'(n));
      chk("occupied", 32'h1, {31'h0, occ});
      fl(8'h00);
      put(sbq_pkg::ID_ACC_NC);
      wr(sbq_pkg::OFF_CNT_UPPER, 8'h60);
      put(sbq_pkg::ID_ACC_NC);
      put(sbq_pkg::ID_GYRO_T2);
      put(sbq_pkg::ID_GYRO_3C);
      fl(8'h80);
      put(sbq_pkg::ID_GYRO_NC);
      rd(sbq_pkg::OFF_FLAGS_UPPER, 8'hff, 8'h90);
      wr(sbq_pkg::OFF_PIN_ROUTE, 8'h01);
      pins(1'b1, 1'b0);
      wr(sbq_pkg::OFF_PIN_ROUTE, 8'h10);
      pins(1'b0, 1'b1);
      wr(sbq_pkg::OFF_PIN_ROUTE, 8'h00);
      wr(sbq_pkg::OFF_PIN_ROUTE, 8'h24);
      // equal rate codes: accel events alone advance the slot count
      repeat (5) pulse(1'b0, 1'b0, 1'b1, 1'b0, 5'h00);
      pulse(1'b0, 1'b0, 1'b0, 1'b1, 5'h00);
      put(sbq_pkg::ID_GYRO_3C);
      rd(sbq_pkg::OFF_WORD_TAG, 8'hff, {sbq_pkg::ID_GYRO_3C, 2'b01, ^{sbq_pkg::ID_GYRO_3C, 2'b01}});
      while (n < 511)
         put(sbq_pkg::ID_ACC_NC);
      fl(8'ha1);
      put(sbq_pkg::ID_ACC_NC);
      rd(sbq_pkg::OFF_LEVEL_LOWER, 8'hff, 8'h00);
      fl(8'ha2);
      put(sbq_pkg::ID_ACC_NC);
      fl(8'hea);
      pins(1'b1, 1'b1);
      fl(8'he2);
      pulse(1'b0, 1'b1, 1'b0, 1'b0, 5'h00);
      fl(8'ha1);
      pins(1'b1, 1'b0);
      wr(sbq_pkg::OFF_MISC, 8'h01);
      rd(sbq_pkg::OFF_LEVEL_LOWER, 8'hff, 8'hff);
      put(sbq_pkg::ID_ACC_NC);
      fl(8'ha1);
      fl(8'ha2);
      complete_run();
   end
endmodule // sbq_status_tb
